// File: pcg_pkg.sv
// Purpose: Constants and helpers for peripheral clock gating
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte address
// Notes:   Shared by all gating files
package pcg_pkg;

  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [11:0] RUN_CLOCK_GATE_1_OFF   = 12'h104;
  localparam logic [11:0] SLEEP_CLOCK_GATE_1_OFF = 12'h114;
  localparam logic [11:0] DEEP_CLOCK_GATE_1_OFF  = 12'h124;
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFF   = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFF         = 12'h200;
  localparam logic [11:0] IRQ_ENABLE_OFF         = 12'h204;
  localparam logic [11:0] IRQ_CLEAR_OFF          = 12'h208;

  // ----------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------
  localparam int          NUM_UNITS       = 7;
  localparam int          ASYNC_SERIAL0_B = 0;
  localparam int          SYNC_SERIAL0_B  = 4;
  localparam int          ENCODER0_B      = 8;
  localparam int          GP_TMR0_B       = 16;
  localparam int          AUTO_GATING_B   = 27;
  localparam logic [31:0] GATE_WR_MASK    = 32'h000f0111;
  localparam logic [31:0] CFG_WR_MASK     = 32'h08000000;
  localparam int          IRQ_W           = 1;
  localparam int          IRQ_FAULT_B     = 0;

  // ----------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] CFG_RESET  = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Byte-lane write merge limited to writable bits
  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~(lanes & mask)) | (data & lanes & mask));
  endfunction

  // Unit index to gating bit position
  function automatic int unitBit(input int idx);
    int pos;
    pos = GP_TMR0_B + idx - 3;
    if (idx == 0) begin
      pos = ASYNC_SERIAL0_B;
    end else if (idx == 1) begin
      pos = SYNC_SERIAL0_B;
    end else if (idx == 2) begin
      pos = ENCODER0_B;
    end
    return pos;
  endfunction

endpackage

// File: pcg_gate_if.sv
// Purpose: Carrier between register block, selector and fault check
// Assumes: One clock domain
// Notes:   Masks are full 32-bit register images
`timescale 1ns/1ps
interface pcg_gate_if;
  logic [31:0]                    runMask;
  logic [31:0]                    sleepMask;
  logic [31:0]                    deepMask;
  logic                           auto_clock_gating;
  logic                           sleepMode;
  logic                           deepMode;
  logic [pcg_pkg::NUM_UNITS-1:0]  unitEn;
  logic                           accValid;
  logic [2:0]                     accSel;
  logic                           accFault;
  logic                           accOk;

  modport ctl (output runMask, sleepMask, deepMask, auto_clock_gating, sleepMode, deepMode, accValid, accSel,
               input unitEn, accFault, accOk);
  modport sel (input runMask, sleepMask, deepMask, auto_clock_gating, sleepMode, deepMode, output unitEn);
  modport chk (input unitEn, accValid, accSel, output accFault, accOk);
endinterface

// File: pcg_gate_sel.sv
// Purpose: Picks the gating register for the current power mode
// Assumes: Sleep and deep-sleep indications are synchronous levels
// Notes:   Unit enables are registered
`timescale 1ns/1ps
module pcg_gate_sel (
  input wire logic clk_sys,
  input wire logic reset_n,
  pcg_gate_if.sel  gif
);

  logic [31:0] activeMask;

  // ----------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------
  always_comb begin
    activeMask = gif.runMask;
    if (gif.auto_clock_gating && gif.deepMode) begin
      activeMask = gif.deepMask;
    end else if (gif.auto_clock_gating && gif.sleepMode) begin
      activeMask = gif.sleepMask;
    end
  end

  // ----------------------------------------------------------
  // Unit clock enables
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gif.unitEn <= '0;
    end else begin
      for (int i = 0; i < pcg_pkg::NUM_UNITS; i++) begin
        gif.unitEn[i] <= activeMask[pcg_pkg::unitBit(i)];
      end
    end
  end

endmodule

// File: pcg_fault_chk.sv
// Purpose: Flags accesses to units whose clock is stopped
// Assumes: One access request per cycle, index 0 to 6
// Notes:   Out-of-range index also faults
`timescale 1ns/1ps
module pcg_fault_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  pcg_gate_if.chk  gif
);

  logic unitOn;

  always_comb begin
    unitOn = 1'b0;
    if (int'(gif.accSel) < pcg_pkg::NUM_UNITS) begin
      unitOn = gif.unitEn[gif.accSel];
    end
  end

  // ----------------------------------------------------------
  // Fault and completion pulses
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gif.accFault <= 1'b0;
      gif.accOk    <= 1'b0;
    end else begin
      gif.accFault <= gif.accValid & ~unitOn;
      gif.accOk    <= gif.accValid & unitOn;
    end
  end

endmodule

// File: pcg_clock_gating.sv
// Purpose: Peripheral clock gating control with AXI4-Lite registers
// Assumes: Single clock clk_sys at 250 MHz, asynchronous active-low reset
// Notes:   Fault events raise a level interrupt through an enable register
//
// Behaviour
// - Bit 0 gates the first asynchronous serial port clock.
// - Bit 4 gates the first synchronous serial port clock.
// - Bit 8 gates the first quadrature encoder clock.
// - Bit one delivers the unit clock; zero stops and disables it.
// - Access to an unclocked unit gives a bus fault.
// - Gating registers reset to all zeros, every unit unclocked.
// - Reserved bits are read-only zero; software preserves them.
// - Three same-layout gating registers; run register governs normal running.
// - Sleep register applies only during sleep.
// - Deep-sleep register at offset 0x124 applies during deep sleep.
// - Sleep and deep-sleep registers act only with auto gating set.
`timescale 1ns/1ps
module pcg_clock_gating (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [11:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [11:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          sleepMode,
  input  wire logic                          deepSleepMode,
  input  wire logic                          unitAccValid,
  input  wire logic [2:0]                    unitAccSel,
  output logic                               unitAccFault,
  output logic                               unitAccOk,
  output logic [pcg_pkg::NUM_UNITS-1:0]      unitClkEn,
  output logic                               irq
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  pcg_gate_if gif ();

  logic [31:0]               run_clock_gate_1_r;
  logic [31:0]               sleep_clock_gate_1_r;
  logic [31:0]               deep_sleep_clock_gate_1_r;
  logic [31:0]               run_clock_config_r;
  logic [pcg_pkg::IRQ_W-1:0] irqStatus_r;
  logic [pcg_pkg::IRQ_W-1:0] irqEnable_r;
  logic [pcg_pkg::IRQ_W-1:0] irqEvent;
  logic [pcg_pkg::IRQ_W-1:0] irqClear;
  logic                      irq_r;

  logic                      awHeld_r;
  logic                      wHeld_r;
  logic                      awReady_r;
  logic                      wReady_r;
  logic [11:0]               awAddr_r;
  logic [31:0]               wData_r;
  logic [3:0]                wStrb_r;
  logic                      bValid_r;
  logic [1:0]                bResp_r;
  logic                      arReady_r;
  logic                      rValid_r;
  logic [31:0]               rData_r;
  logic [1:0]                rResp_r;

  logic                      wrFire;
  logic                      wrHit;
  logic                      arFire;
  logic [31:0]               rdMux;
  logic                      rdHit;

  // ----------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------
  pcg_gate_sel u_sel (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .gif     (gif.sel)
  );

  pcg_fault_chk u_chk (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .gif     (gif.chk)
  );

  // ----------------------------------------------------------
  // Carrier hookup
  // ----------------------------------------------------------
  // run register image
  assign gif.runMask   = run_clock_gate_1_r;
  assign gif.sleepMask = sleep_clock_gate_1_r;
  assign gif.deepMask  = deep_sleep_clock_gate_1_r;
  assign gif.auto_clock_gating       = run_clock_config_r[pcg_pkg::AUTO_GATING_B];
  assign gif.sleepMode = sleepMode;
  assign gif.deepMode  = deepSleepMode;
  assign gif.accValid  = unitAccValid;
  assign gif.accSel    = unitAccSel;

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // registered unit enables
  assign unitClkEn     = gif.unitEn;
  assign unitAccFault  = gif.accFault;
  assign unitAccOk     = gif.accOk;
  assign irq           = irq_r;
  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // ----------------------------------------------------------
  // Word address match
  // ----------------------------------------------------------
  function automatic logic sameWord(input logic [11:0] addr,
                                    input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction

  // ----------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------
  assign wrFire = awHeld_r & wHeld_r & ~bValid_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      awReady_r <= 1'b1;
      awAddr_r <= 12'h000;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awHeld_r <= 1'b1;
      awReady_r <= 1'b0;
      awAddr_r <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
      awReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wHeld_r <= 1'b0;
      wReady_r <= 1'b1;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wHeld_r <= 1'b1;
      wReady_r <= 1'b0;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
      wReady_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Write address decode
  // ----------------------------------------------------------
  always_comb begin
    case (awAddr_r[11:2])
      pcg_pkg::RUN_CLOCK_GATE_1_OFF[11:2]:   wrHit = 1'b1;
      pcg_pkg::SLEEP_CLOCK_GATE_1_OFF[11:2]: wrHit = 1'b1;
      pcg_pkg::DEEP_CLOCK_GATE_1_OFF[11:2]:  wrHit = 1'b1;
      pcg_pkg::RUN_CLOCK_CONFIG_OFF[11:2]:   wrHit = 1'b1;
      pcg_pkg::IRQ_STATUS_OFF[11:2]:         wrHit = 1'b1;
      pcg_pkg::IRQ_ENABLE_OFF[11:2]:         wrHit = 1'b1;
      pcg_pkg::IRQ_CLEAR_OFF[11:2]:          wrHit = 1'b1;
      default:                               wrHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Write response
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bValid_r <= 1'b0;
      bResp_r  <= pcg_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bValid_r <= 1'b1;
      bResp_r  <= wrHit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Gating and run clock configuration registers
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_clock_gate_1_r <= pcg_pkg::GATE_RESET;
    end else if (wrFire && sameWord(awAddr_r, pcg_pkg::RUN_CLOCK_GATE_1_OFF)) begin
      run_clock_gate_1_r <= pcg_pkg::wrMerge(run_clock_gate_1_r, wData_r, wStrb_r,
                                             pcg_pkg::GATE_WR_MASK);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sleep_clock_gate_1_r <= pcg_pkg::GATE_RESET;
    end else if (wrFire && sameWord(awAddr_r, pcg_pkg::SLEEP_CLOCK_GATE_1_OFF)) begin
      sleep_clock_gate_1_r <= pcg_pkg::wrMerge(sleep_clock_gate_1_r, wData_r, wStrb_r,
                                               pcg_pkg::GATE_WR_MASK);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deep_sleep_clock_gate_1_r <= pcg_pkg::GATE_RESET;
    end else if (wrFire && sameWord(awAddr_r, pcg_pkg::DEEP_CLOCK_GATE_1_OFF)) begin
      deep_sleep_clock_gate_1_r <= pcg_pkg::wrMerge(deep_sleep_clock_gate_1_r, wData_r, wStrb_r,
                                                    pcg_pkg::GATE_WR_MASK);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_clock_config_r <= pcg_pkg::CFG_RESET;
    end else if (wrFire && sameWord(awAddr_r, pcg_pkg::RUN_CLOCK_CONFIG_OFF)) begin
      run_clock_config_r <= pcg_pkg::wrMerge(run_clock_config_r, wData_r, wStrb_r,
                                             pcg_pkg::CFG_WR_MASK);
    end
  end

  // ----------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------
  always_comb begin
    irqEvent = '0;
    irqEvent[pcg_pkg::IRQ_FAULT_B] = gif.accFault;
    irqClear = '0;
    if (wrFire && wStrb_r[0] && sameWord(awAddr_r, pcg_pkg::IRQ_CLEAR_OFF)) begin
      irqClear = wData_r[pcg_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_r <= '0;
    end else begin
      irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvent;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqEnable_r <= '0;
    end else if (wrFire && wStrb_r[0] && sameWord(awAddr_r, pcg_pkg::IRQ_ENABLE_OFF)) begin
      irqEnable_r <= wData_r[pcg_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irqStatus_r & irqEnable_r);
    end
  end

  // ----------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------
  always_comb begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (s_axi_araddr[11:2])
      pcg_pkg::RUN_CLOCK_GATE_1_OFF[11:2]:   rdMux = run_clock_gate_1_r;
      pcg_pkg::SLEEP_CLOCK_GATE_1_OFF[11:2]: rdMux = sleep_clock_gate_1_r;
      pcg_pkg::DEEP_CLOCK_GATE_1_OFF[11:2]:  rdMux = deep_sleep_clock_gate_1_r;
      pcg_pkg::RUN_CLOCK_CONFIG_OFF[11:2]:   rdMux = run_clock_config_r;
      pcg_pkg::IRQ_STATUS_OFF[11:2]:         rdMux[pcg_pkg::IRQ_W-1:0] = irqStatus_r;
      pcg_pkg::IRQ_ENABLE_OFF[11:2]:         rdMux[pcg_pkg::IRQ_W-1:0] = irqEnable_r;
      pcg_pkg::IRQ_CLEAR_OFF[11:2]:          rdMux = 32'h00000000;
      default:                               rdHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------
  assign arFire = s_axi_arvalid & arReady_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arReady_r <= 1'b0;
    end else if (arFire) begin
      arReady_r <= 1'b0;
    end else begin
      arReady_r <= ~rValid_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h00000000;
      rResp_r  <= pcg_pkg::RESP_OKAY;
    end else if (arFire) begin
      rValid_r <= 1'b1;
      rData_r  <= rdMux;
      rResp_r  <= rdHit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

endmodule

// File: pcg_clock_gating_chk.sv
// Purpose: Port assertions for the clock gating block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module pcg_clock_gating_chk (
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_rvalid,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          unitAccValid,
  input wire logic [2:0]                    unitAccSel,
  input wire logic                          unitAccFault,
  input wire logic                          unitAccOk,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unitClkEn,
  input wire logic                          irq
);
  // ------------------------------------------------------------
  // Clocking
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  gated_fault_a: assert property (
    unitAccValid && unitAccSel != 3'h7 && !unitClkEn[unitAccSel] |=> unitAccFault && !unitAccOk)
    else $error("access to stopped unit not faulted");
  clocked_ok_a: assert property (
    unitAccValid && unitAccSel != 3'h7 && unitClkEn[unitAccSel] |=> unitAccOk && !unitAccFault)
    else $error("access to clocked unit not completed");
  bad_sel_a: assert property (
    unitAccValid && unitAccSel == 3'h7 |=> unitAccFault)
    else $error("unknown unit index not faulted");
  idle_quiet_a: assert property (
    !unitAccValid |=> !unitAccFault && !unitAccOk)
    else $error("access answer without request");
  reset_off_a: assert property (
    $rose(reset_n) |-> unitClkEn == '0 && !irq)
    else $error("unit clocked after reset");
  resv_zero_a: assert property (
    s_axi_rvalid |-> (s_axi_rdata & ~(pcg_pkg::GATE_WR_MASK | pcg_pkg::CFG_WR_MASK)) == 32'h0)
    else $error("reserved read data not zero");
  irq_rise_a: assert property (
    $rose(irq) |-> $past(unitAccFault, 2) || $past(s_axi_bvalid))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt fell without write");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  cover property (unitAccFault);
  cover property (unitAccOk);
  cover property ($rose(irq));
endmodule

// File: tb_pcg_clock_gating.sv
// Purpose: Self-checking bench for the clock gating block
// Assumes: 250 MHz clk_sys, AXI4-Lite master tasks
// Notes:   Checker bound at the foot of this file
`timescale 1ns/1ps
module tb_pcg_clock_gating;
  localparam logic [11:0] RUN  = pcg_pkg::RUN_CLOCK_GATE_1_OFF;
  localparam logic [11:0] SLP  = pcg_pkg::SLEEP_CLOCK_GATE_1_OFF;
  localparam logic [11:0] DEEP = pcg_pkg::DEEP_CLOCK_GATE_1_OFF;
  localparam logic [11:0] CFG  = pcg_pkg::RUN_CLOCK_CONFIG_OFF;
  localparam logic [11:0] IST  = pcg_pkg::IRQ_STATUS_OFF;
  localparam logic [11:0] IEN  = pcg_pkg::IRQ_ENABLE_OFF;
  localparam logic [11:0] ICL  = pcg_pkg::IRQ_CLEAR_OFF;
  localparam logic [1:0]  OK   = pcg_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR  = pcg_pkg::RESP_SLVERR;

  logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sleepMode, deepSleepMode, unitAccValid, unitAccFault, unitAccOk, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mapW;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  unitAccSel;
  logic [6:0]  unitClkEn;
  int          failCount = 0, totalChecks = 0, cycles = 0;
  int          bitPos[7] = '{0, 4, 8, 16, 17, 18, 19};
  logic [11:0] regs[7] = '{RUN, SLP, DEEP, CFG, IST, IEN, ICL};

  pcg_clock_gating u_dut (
    .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sleepMode, .deepSleepMode, .unitAccValid, .unitAccSel, .unitAccFault,
    .unitAccOk, .unitClkEn, .irq
  );

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      printVerdict();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("Checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axiRd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, ed);
    check(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic acc(input logic [2:0] s, input logic f);
    @(posedge clk_sys);
    unitAccSel <= s;
    unitAccValid <= 1'h1;
    @(posedge clk_sys);
    unitAccValid <= 1'h0;
    #1;
    check(32'(unitAccFault), 32'(f));
    check(32'(unitAccOk), 32'(!f));
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {sleepMode, deepSleepMode, unitAccValid} = 3'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    unitAccSel = 3'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    #1;
    check(32'(unitClkEn), 32'h0);
    foreach (regs[i]) axiRd(regs[i], 32'h0, OK);
    axiRd(12'h300, 32'h0, ERR);
    axiWr(12'h300, 32'hffffffff, ERR);
    for (int s = 0; s < 8; s++) acc(3'(s), 1'h1);
    settle();
    check(32'(irq), 32'h0);
    axiRd(IST, 32'h1, OK);
    axiWr(IEN, 32'h1, OK);
    settle();
    check(32'(irq), 32'h1);
    axiWr(IST, 32'h0, OK);
    axiRd(IST, 32'h1, OK);
    axiWr(ICL, 32'h1, OK);
    axiRd(IST, 32'h0, OK);
    settle();
    check(32'(irq), 32'h0);
    for (int i = 0; i < 7; i++) begin
      mapW = 32'h1 << bitPos[i];
      axiWr(RUN, mapW | 32'hfff0feee, OK);
      axiRd(RUN, mapW, OK);
      #1;
      check(32'(unitClkEn), 32'h1 << i);
      acc(3'(i), 1'h0);
      acc(3'((i + 1) % 7), 1'h1);
    end
    axiWr(RUN, 32'hffffffff, OK);
    axiRd(RUN, pcg_pkg::GATE_WR_MASK, OK);
    axiWr(SLP, 32'h1, OK);
    axiWr(DEEP, 32'h10, OK);
    axiRd(DEEP, 32'h10, OK);
    sleepMode <= 1'h1;
    deepSleepMode <= 1'h1;
    settle();
    check(32'(unitClkEn), 32'h7f);
    axiWr(CFG, 32'hffffffff, OK);
    axiRd(CFG, 32'h08000000, OK);
    settle();
    check(32'(unitClkEn), 32'h02);
    acc(3'h0, 1'h1);
    @(posedge clk_sys);
    deepSleepMode <= 1'h0;
    settle();
    check(32'(unitClkEn), 32'h01);
    @(posedge clk_sys);
    sleepMode <= 1'h0;
    settle();
    check(32'(unitClkEn), 32'h7f);
    s_axi_wstrb <= 4'h4;
    axiWr(RUN, 32'h0, OK);
    s_axi_wstrb <= 4'hf;
    axiRd(RUN, 32'h00000111, OK);
    settle();
    check(32'(unitClkEn), 32'h07);
    printVerdict();
  end
endmodule

bind pcg_clock_gating pcg_clock_gating_chk u_portChk (
  .clk_sys, .reset_n, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .unitAccValid,
  .unitAccSel, .unitAccFault, .unitAccOk, .unitClkEn, .irq
);
